// >>> nlr_map.svh
// constants for the negate, logic and rotate execution unit
`ifndef NLR_MAP_SVH
`define NLR_MAP_SVH
`define NLR_WORD_W 32
`define NLR_REG_IDX_W 4
`define NLR_PC_STEP 32'h0000_0002
`define NLR_CODE_NEGATE 16'h600b
`define NLR_CODE_NEGATE_BORROW 16'h600a
`define NLR_CODE_NO_OPERATION 16'h0009
`define NLR_CODE_NOT 16'h6007
`define NLR_CODE_OR_REG 16'h200b
`define NLR_CODE_OR_IMM 16'hcb00
`define NLR_CODE_OR_MEM 16'hcf00
`define NLR_CODE_ROTATE_CARRY_LEFT 16'h4024
`define NLR_CODE_ROTATE_CARRY_RIGHT 16'h4025
`define NLR_CODE_ROTATE_LEFT 16'h4004
`define NLR_CODE_ROTATE_RIGHT 16'h4005
`define NLR_MASK_REG2 16'hf00f
`define NLR_MASK_REG1 16'hf0ff
`define NLR_MASK_IMM 16'hff00
`define NLR_MASK_FULL 16'hffff
`define NLR_MEM_CYCLES 3
`endif

// >>> nlr_pkg.sv
// types shared by the negate, logic and rotate execution unit
package nlr_pkg;
   typedef enum {
      op_none, negate_op, negate_with_borrow_op, no_operation_op, complement_op, or_reg_op, or_imm_op, or_mem_op,
      rotate_left_through_carry_op, rotate_right_through_carry_op, rotate_left_op, rotate_right_op
   } op_t;
   typedef enum {st_idle, st_read, st_write} mem_state_t;
endpackage : nlr_pkg

// >>> nlr_decode.sv
// opcode decoder for the negate, logic and rotate execution unit
`timescale 1ns/10ps
`include "nlr_map.svh"
module nlr_decode (
   // instruction word
   input wire logic [15:0] i_code,
   // decoded operation
   output nlr_pkg::op_t o_op
);
   function automatic logic hit(input logic [15:0] code, input logic [15:0] mask, input logic [15:0] pat);
      hit = (code & mask) == pat;
   endfunction : hit

   always_comb begin
      o_op = nlr_pkg::op_none;
      if (hit(i_code, `NLR_MASK_REG2, `NLR_CODE_NEGATE)) o_op = nlr_pkg::negate_op;
      else if (hit(i_code, `NLR_MASK_REG2, `NLR_CODE_NEGATE_BORROW)) o_op = nlr_pkg::negate_with_borrow_op;
      else if (hit(i_code, `NLR_MASK_FULL, `NLR_CODE_NO_OPERATION)) o_op = nlr_pkg::no_operation_op;
      else if (hit(i_code, `NLR_MASK_REG2, `NLR_CODE_NOT)) o_op = nlr_pkg::complement_op;
      else if (hit(i_code, `NLR_MASK_REG2, `NLR_CODE_OR_REG)) o_op = nlr_pkg::or_reg_op;
      else if (hit(i_code, `NLR_MASK_IMM, `NLR_CODE_OR_IMM)) o_op = nlr_pkg::or_imm_op;
      else if (hit(i_code, `NLR_MASK_IMM, `NLR_CODE_OR_MEM)) o_op = nlr_pkg::or_mem_op;
      else if (hit(i_code, `NLR_MASK_REG1, `NLR_CODE_ROTATE_CARRY_LEFT)) o_op = nlr_pkg::rotate_left_through_carry_op;
      else if (hit(i_code, `NLR_MASK_REG1, `NLR_CODE_ROTATE_CARRY_RIGHT)) o_op = nlr_pkg::rotate_right_through_carry_op;
      else if (hit(i_code, `NLR_MASK_REG1, `NLR_CODE_ROTATE_LEFT)) o_op = nlr_pkg::rotate_left_op;
      else if (hit(i_code, `NLR_MASK_REG1, `NLR_CODE_ROTATE_RIGHT)) o_op = nlr_pkg::rotate_right_op;
   end
endmodule : nlr_decode

// >>> negate_logic_rotate_unit.sv
// execution unit for negate, complement, or, no-operation and single-bit rotates
`timescale 1ns/10ps
`include "nlr_map.svh"
// Functional notes
// [RQ1] negate writes zero minus source, carry kept
// [RQ2] negate with borrow subtracts carry, borrow out
// [RQ3] software clears carry, negates words low first
// [RQ4] no-operation only advances program counter
// [RQ5] complement writes inverted source, carry kept
// [RQ6] register or merges source into destination
// [RQ7] immediate or zero-extends byte into register zero
// [RQ8] memory or reads, merges, writes byte, three cycles
// [RQ9] rotate left through carry swaps msb and carry
// [RQ10] rotate right through carry swaps lsb and carry
// [RQ11] rotate left copies msb to lsb and carry
// [RQ12] rotate right copies lsb to msb and carry
// [RQ13] every instruction advances counter by two
// [RQ14] rotates take one cycle, touch operand and carry only
module negate_logic_rotate_unit (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // instruction issue from the decoder
   input wire logic i_issue,
   input wire logic [15:0] i_code,
   input wire logic [31:0] i_pc,
   // operands from the register file
   input wire logic [31:0] i_src_data,
   input wire logic [31:0] i_dst_data,
   input wire logic [31:0] i_reg_zero_data,
   input wire logic [31:0] i_global_base_register,
   input wire logic i_carry,
   // memory port
   input wire logic [7:0] i_mem_rdata,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [31:0] o_mem_addr,
   output logic [7:0] o_mem_wdata,
   // write back
   output logic o_reg_we,
   output logic [3:0] o_reg_idx,
   output logic [31:0] o_reg_data,
   output logic o_carry_we,
   output logic o_carry,
   output logic o_pc_we,
   output logic [31:0] o_pc,
   output logic o_busy
);
   nlr_pkg::op_t op;
   nlr_pkg::mem_state_t st_q;
   nlr_pkg::mem_state_t st_d;
   logic [31:0] result;
   logic carry_new;
   logic writes_reg;
   logic writes_carry;
   logic [7:0] imm_q;
   logic [31:0] addr_q;
   logic [31:0] pc_q;
   logic [32:0] negated_full;

   nlr_decode u_decode (
      .i_code(i_code),
      .o_op(op)
   );

   wire [3:0] dst_idx = i_code[11:8];
   wire [31:0] imm_ext = {24'h00_0000, i_code[7:0]}; // [RQ7]
   wire accept = i_issue && st_q == nlr_pkg::st_idle;
   wire start_mem = accept && op == nlr_pkg::or_mem_op;
   wire [31:0] pc_next = i_pc + `NLR_PC_STEP; // [RQ13]
   // borrow is the top bit of a 33-bit subtraction from zero
   assign negated_full = 33'h0_0000_0000 - {1'b0, i_src_data} - {32'h0000_0000, i_carry}; // [RQ2]

   always_comb begin
      result = i_dst_data;
      carry_new = i_carry;
      writes_reg = 1'b1;
      writes_carry = 1'b0;
      case (op)
         nlr_pkg::negate_op: result = 32'h0000_0000 - i_src_data; // [RQ1]
         nlr_pkg::negate_with_borrow_op: begin
            result = negated_full[31:0]; // [RQ2]
            carry_new = negated_full[32];
            writes_carry = 1'b1;
         end
         nlr_pkg::complement_op: result = ~i_src_data; // [RQ5]
         nlr_pkg::or_reg_op: result = i_dst_data | i_src_data; // [RQ6]
         nlr_pkg::or_imm_op: result = i_reg_zero_data | imm_ext; // [RQ7]
         nlr_pkg::rotate_left_through_carry_op: begin
            result = {i_dst_data[30:0], i_carry}; // [RQ9]
            carry_new = i_dst_data[31];
            writes_carry = 1'b1;
         end
         nlr_pkg::rotate_right_through_carry_op: begin
            result = {i_carry, i_dst_data[31:1]}; // [RQ10]
            carry_new = i_dst_data[0];
            writes_carry = 1'b1;
         end
         nlr_pkg::rotate_left_op: begin
            result = {i_dst_data[30:0], i_dst_data[31]}; // [RQ11]
            carry_new = i_dst_data[31];
            writes_carry = 1'b1;
         end
         nlr_pkg::rotate_right_op: begin
            result = {i_dst_data[0], i_dst_data[31:1]}; // [RQ12]
            carry_new = i_dst_data[0];
            writes_carry = 1'b1;
         end
         default: writes_reg = 1'b0; // [RQ4] no-operation, memory or and unknown codes
      endcase
   end

   // memory or: issue cycle latches address, read cycle merges, write cycle stores
   always_comb begin
      case (st_q)
         nlr_pkg::st_idle: st_d = start_mem ? nlr_pkg::st_read : nlr_pkg::st_idle;
         nlr_pkg::st_read: st_d = nlr_pkg::st_write;
         nlr_pkg::st_write: st_d = nlr_pkg::st_idle;
         default: st_d = nlr_pkg::st_idle;
      endcase
   end

   wire single = accept && op != nlr_pkg::op_none && op != nlr_pkg::or_mem_op;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_q <= nlr_pkg::st_idle;
         imm_q <= 8'h00;
         addr_q <= 32'h0000_0000;
         pc_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         if (start_mem) begin
            imm_q <= i_code[7:0];
            addr_q <= i_reg_zero_data + i_global_base_register; // [RQ8]
            pc_q <= pc_next;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_we <= 1'b0;
         o_reg_idx <= 4'h0;
         o_reg_data <= 32'h0000_0000;
         o_carry_we <= 1'b0;
         o_carry <= 1'b0;
         o_pc_we <= 1'b0;
         o_pc <= 32'h0000_0000;
      end else begin
         o_reg_we <= single && writes_reg; // [RQ14]
         o_reg_idx <= (op == nlr_pkg::or_imm_op) ? 4'h0 : dst_idx;
         o_reg_data <= result;
         o_carry_we <= single && writes_carry; // [RQ1] [RQ5] [RQ6] carry kept
         o_carry <= carry_new;
         o_pc_we <= single || st_q == nlr_pkg::st_write; // [RQ13]
         o_pc <= (st_q == nlr_pkg::st_write) ? pc_q : pc_next;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         o_mem_addr <= 32'h0000_0000;
         o_mem_wdata <= 8'h00;
         o_busy <= 1'b0;
      end else begin
         o_mem_rd <= start_mem; // [RQ8]
         o_mem_wr <= st_q == nlr_pkg::st_read;
         o_mem_addr <= start_mem ? i_reg_zero_data + i_global_base_register : addr_q;
         o_mem_wdata <= i_mem_rdata | imm_q; // [RQ8]
         o_busy <= st_d != nlr_pkg::st_idle;
      end
   end

   // one-cycle ops answer the next edge; memory or spans three edges
   single_cycle_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ13]
      single |=> o_pc_we && o_pc == $past(i_pc) + `NLR_PC_STEP) else $error("pc not advanced by two");
   neg_value_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ1]
      accept && op == nlr_pkg::negate_op |=> o_reg_we && o_reg_data == -$past(i_src_data) && !o_carry_we)
      else $error("negate result wrong");
   borrow_out_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ2]
      accept && op == nlr_pkg::negate_with_borrow_op |=> o_carry_we
      && o_carry == ($past(i_src_data) != 32'h0 || $past(i_carry))) else $error("borrow wrong");
   borrow_value_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ2]
      accept && op == nlr_pkg::negate_with_borrow_op |=> o_reg_we
      && o_reg_data == 32'h0000_0000 - $past(i_src_data) - {31'h0000_0000, $past(i_carry)})
      else $error("negate with borrow result wrong");
   idle_op_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ4]
      accept && op == nlr_pkg::no_operation_op |=> !o_reg_we && !o_carry_we && o_pc_we)
      else $error("no-operation changed state");
   not_value_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ5]
      accept && op == nlr_pkg::complement_op |=> o_reg_data == ~$past(i_src_data) && !o_carry_we)
      else $error("complement wrong");
   or_reg_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ6]
      accept && op == nlr_pkg::or_reg_op |=> o_reg_data == ($past(i_src_data) | $past(i_dst_data)))
      else $error("or register wrong");
   or_carry_kept_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ6]
      accept && (op == nlr_pkg::or_reg_op || op == nlr_pkg::or_imm_op) |=> o_reg_we && !o_carry_we)
      else $error("or changed carry");
   or_imm_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ7]
      accept && op == nlr_pkg::or_imm_op |=> o_reg_idx == 4'h0
      && o_reg_data == ($past(i_reg_zero_data) | {24'h0, $past(i_code[7:0])})) else $error("or imm wrong");
   or_mem_seq_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ8]
      start_mem |=> o_mem_rd ##1 o_mem_wr && !o_pc_we ##1 o_pc_we && !o_busy) else $error("memory or sequence");
   or_mem_addr_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ8]
      start_mem |=> o_mem_addr == $past(i_reg_zero_data) + $past(i_global_base_register)
      && !o_reg_we && !o_carry_we)
      else $error("memory or address wrong");
   carry_left_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ9]
      accept && op == nlr_pkg::rotate_left_through_carry_op |=> o_carry == $past(i_dst_data[31])
      && o_reg_data[0] == $past(i_carry)) else $error("rotate carry left wrong");
   carry_right_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ10]
      accept && op == nlr_pkg::rotate_right_through_carry_op |=> o_carry == $past(i_dst_data[0])
      && o_reg_data[31] == $past(i_carry)) else $error("rotate carry right wrong");
   rotate_left_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ11]
      accept && op == nlr_pkg::rotate_left_op |=> o_reg_data[0] == o_carry && o_carry == $past(i_dst_data[31]))
      else $error("rotate left wrong");
   rotate_right_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ12]
      accept && op == nlr_pkg::rotate_right_op |=> o_reg_data[31] == o_carry && o_carry == $past(i_dst_data[0]))
      else $error("rotate right wrong");
   rot_target_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ14]
      accept && op == nlr_pkg::rotate_right_op |=> o_reg_idx == $past(i_code[11:8]) && !o_mem_wr)
      else $error("rotate touched other state");
   rot_left_target_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ14]
      accept && op == nlr_pkg::rotate_left_through_carry_op |=> o_reg_we && o_reg_idx == $past(i_code[11:8]))
      else $error("rotate wrote wrong register");
   borrow_cover_c: cover property (@(posedge i_clock) accept && op == nlr_pkg::negate_with_borrow_op && i_carry);
   or_mem_cover_c: cover property (@(posedge i_clock) start_mem ##2 o_mem_wr);
   carry_left_cover_c: cover property (@(posedge i_clock) accept && op == nlr_pkg::rotate_left_through_carry_op);
   back_cover_c: cover property (@(posedge i_clock) single ##1 single);
endmodule : negate_logic_rotate_unit

// >>> nlr_mem_model.sv
// byte memory standing at the unit's memory port, answering reads combinationally
`timescale 1ns/10ps
module nlr_mem_model (
   // clock
   input wire logic i_clock,
   // memory port from the unit
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [31:0] i_addr,
   input wire logic [7:0] i_wdata,
   // read return
   output logic [7:0] o_rdata
);
   logic [7:0] mem_q [16];
   logic [7:0] last_q;
   // outside a read the line shows the inverse of the last byte, so a late sample is caught
   assign o_rdata = i_rd ? mem_q[i_addr[3:0]] : ~last_q;
   initial begin
      for (int k = 0; k < 16; k++) begin
         mem_q[k] = 8'h5a ^ 8'(k);
      end
      last_q = 8'h00;
   end
   always @(posedge i_clock) begin
      if (i_rd) begin
         last_q <= mem_q[i_addr[3:0]];
      end
      if (i_wr) begin
         mem_q[i_addr[3:0]] <= i_wdata;
      end
   end
endmodule : nlr_mem_model

// >>> negate_logic_rotate_unit_test.sv
// self-checking bench for the negate, logic and rotate execution unit
`timescale 1ns/10ps
`include "nlr_map.svh"
`define CHECK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected %s expected %h seen %h", what, exp, got); end end
module negate_logic_rotate_unit_test;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_issue = 1'b0;
   logic [15:0] i_code = 16'h0000;
   logic [31:0] i_pc = 32'h0000_1000;
   logic [31:0] i_src_data = 32'h0000_0000;
   logic [31:0] i_dst_data = 32'h0000_0000;
   logic [31:0] i_reg_zero_data = 32'h0000_0000;
   logic [31:0] i_global_base_register = 32'h0000_0000;
   logic i_carry = 1'b0;
   logic [7:0] i_mem_rdata;
   logic o_mem_rd, o_mem_wr, o_reg_we, o_carry_we, o_carry, o_pc_we, o_busy;
   logic [31:0] o_mem_addr, o_reg_data, o_pc;
   logic [7:0] o_mem_wdata;
   logic [3:0] o_reg_idx;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   always #5 i_clock = ~i_clock;
   negate_logic_rotate_unit DUT (.i_clock(i_clock), .i_rst(i_rst), .i_issue(i_issue), .i_code(i_code),
      .i_pc(i_pc), .i_src_data(i_src_data), .i_dst_data(i_dst_data), .i_reg_zero_data(i_reg_zero_data),
      .i_global_base_register(i_global_base_register), .i_carry(i_carry), .i_mem_rdata(i_mem_rdata),
      .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
      .o_reg_we(o_reg_we), .o_reg_idx(o_reg_idx), .o_reg_data(o_reg_data), .o_carry_we(o_carry_we),
      .o_carry(o_carry), .o_pc_we(o_pc_we), .o_pc(o_pc), .o_busy(o_busy));
   nlr_mem_model partner (.i_clock(i_clock), .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_addr(o_mem_addr),
      .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
   // issue stays high afterwards so operations run back to back
   task automatic run(input logic [15:0] code, input logic [31:0] src, input logic [31:0] dst, input logic c);
      i_pc = i_pc + `NLR_PC_STEP;
      i_code = code;
      i_src_data = src;
      i_dst_data = dst;
      i_carry = c;
      i_issue = 1'b1;
      @(posedge i_clock);
      #1;
   endtask : run
   task automatic expect_wb(input logic we, input logic [3:0] idx, input logic [31:0] data, input logic cwe,
      input logic c, input logic pwe);
      `CHECK("reg write", we, o_reg_we)
      if (we) begin
         `CHECK("reg index", idx, o_reg_idx)
         `CHECK("reg data", data, o_reg_data)
      end
      `CHECK("carry write", cwe, o_carry_we)
      if (cwe) `CHECK("carry", c, o_carry)
      `CHECK("pc write", pwe, o_pc_we)
      if (pwe) `CHECK("pc", i_pc + `NLR_PC_STEP, o_pc)
   endtask : expect_wb
   task automatic t_negate();
      run(`NLR_CODE_NEGATE | 16'h0530, 32'h0000_0001, 32'h1234_5678, 1'b1);
      expect_wb(1'b1, 4'h5, 32'hffff_ffff, 1'b0, 1'b0, 1'b1);
      run(`NLR_CODE_NEGATE | 16'h0530, 32'h8000_0000, 32'h0000_0000, 1'b0);
      expect_wb(1'b1, 4'h5, 32'h8000_0000, 1'b0, 1'b0, 1'b1);
   endtask : t_negate
   // 64-bit sign inversion of one: carry cleared, low word first, high word takes the low word's borrow
   task automatic t_multiword();
      run(`NLR_CODE_NEGATE_BORROW | 16'h0110, 32'h0000_0001, 32'h0000_0001, 1'b0);
      expect_wb(1'b1, 4'h1, 32'hffff_ffff, 1'b1, 1'b1, 1'b1);
      run(`NLR_CODE_NEGATE_BORROW | 16'h0000, 32'h0000_0000, 32'h0000_0000, o_carry);
      expect_wb(1'b1, 4'h0, 32'hffff_ffff, 1'b1, 1'b1, 1'b1);
      run(`NLR_CODE_NEGATE_BORROW | 16'h0000, 32'h0000_0000, 32'h0000_0000, 1'b0);
      expect_wb(1'b1, 4'h0, 32'h0000_0000, 1'b1, 1'b0, 1'b1);
   endtask : t_multiword
   task automatic t_logic();
      run(`NLR_CODE_NO_OPERATION, 32'h1111_1111, 32'h2222_2222, 1'b1);
      expect_wb(1'b0, 4'h0, 32'h0000_0000, 1'b0, 1'b0, 1'b1);
      run(16'hffff, 32'h1111_1111, 32'h2222_2222, 1'b1);
      expect_wb(1'b0, 4'h0, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
      run(`NLR_CODE_NOT | 16'h0100, 32'haaaa_aaaa, 32'h0000_0000, 1'b1);
      expect_wb(1'b1, 4'h1, 32'h5555_5555, 1'b0, 1'b0, 1'b1);
      run(`NLR_CODE_OR_REG | 16'h0100, 32'haaaa_5555, 32'h5555_0000, 1'b1);
      expect_wb(1'b1, 4'h1, 32'hffff_5555, 1'b0, 1'b0, 1'b1);
      i_reg_zero_data = 32'h8000_0008;
      run(`NLR_CODE_OR_IMM | 16'h00f0, 32'h0000_0000, 32'h0000_0000, 1'b0);
      expect_wb(1'b1, 4'h0, 32'h8000_00f8, 1'b0, 1'b0, 1'b1);
   endtask : t_logic
   task automatic t_rotates();
      logic [15:0] codes [4];
      logic [31:0] d;
      logic [31:0] ed;
      logic ec;
      codes = '{`NLR_CODE_ROTATE_CARRY_LEFT, `NLR_CODE_ROTATE_CARRY_RIGHT, `NLR_CODE_ROTATE_LEFT,
         `NLR_CODE_ROTATE_RIGHT};
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 4; k++) begin
            d = (c == 1) ? 32'h4000_0001 : 32'h8000_0002;
            ed = (k == 0) ? {d[30:0], c[0]} : (k == 1) ? {c[0], d[31:1]} : (k == 2) ? {d[30:0], d[31]} :
               {d[0], d[31:1]};
            ec = (k == 0 || k == 2) ? d[31] : d[0];
            run(codes[k] | 16'h0500, 32'hffff_ffff, d, c[0]);
            expect_wb(1'b1, 4'h5, ed, 1'b1, ec, 1'b1);
         end
      end
   endtask : t_rotates
   // a complement issued during the read and write cycles must be dropped;
   // a second memory or to the same byte reads back what the first one wrote
   task automatic t_or_mem();
      i_reg_zero_data = 32'h0000_0013;
      i_global_base_register = 32'h0000_0100;
      run(`NLR_CODE_OR_MEM | 16'h00a1, 32'h0000_0000, 32'h0000_0000, 1'b0);
      `CHECK("read strobe", 1'b1, o_mem_rd)
      `CHECK("address", 32'h0000_0113, o_mem_addr)
      `CHECK("busy", 1'b1, o_busy)
      i_code = `NLR_CODE_NOT | 16'h0530;
      @(posedge i_clock);
      #1;
      `CHECK("write strobe", 1'b1, o_mem_wr)
      `CHECK("write byte", (8'h5a ^ 8'h03) | 8'ha1, o_mem_wdata)
      `CHECK("write address", 32'h0000_0113, o_mem_addr)
      `CHECK("reg write in read cycle", 1'b0, o_reg_we)
      `CHECK("busy in read cycle", 1'b1, o_busy)
      @(posedge i_clock);
      #1;
      `CHECK("busy", 1'b0, o_busy)
      `CHECK("write strobe", 1'b0, o_mem_wr)
      expect_wb(1'b0, 4'h0, 32'h0000_0000, 1'b0, 1'b0, 1'b1);
      run(`NLR_CODE_OR_MEM | 16'h0004, 32'h0000_0000, 32'h0000_0000, 1'b0);
      `CHECK("second read strobe", 1'b1, o_mem_rd)
      @(posedge i_clock);
      #1;
      `CHECK("byte read back", 8'hfd, o_mem_wdata)
      @(posedge i_clock);
      #1;
      expect_wb(1'b0, 4'h0, 32'h0000_0000, 1'b0, 1'b0, 1'b1);
   endtask : t_or_mem
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      `CHECK("pc write after reset", 1'b0, o_pc_we)
      t_negate();
      t_multiword();
      t_logic();
      t_rotates();
      t_or_mem();
      t_logic();
      print_verdict();
   end
endmodule : negate_logic_rotate_unit_test
